// File: hw/count_timer.sv
// 16-bit timer/counter with Avalon-MM register slave
//
// Notes on behaviour
// - count 0000h to FFFFh, wrap to zero
// - wrap latches flag; irq needs enable
// - bit 7 selects 16-bit or byte access
// - bits 6,3 pick compare unit time base
// - bits 5-4 prescale 1,2,4,8
// - bit 2 unsynced external only, else ignored
// - external source; count after first fall
// - internal clock is instruction cycle rate
// - external counts input or oscillator edges
// - bit 0 runs or stops counter
// - oscillator enable makes oscillator usable
// - oscillator enabled forces its pins input
// - trigger mode 1011 clears counter
// - trigger clear never sets overflow flag
// - software write beats trigger clear
// - compare value acts as period
// - power-on clears control; others keep
// - count bytes kept across other resets
// - low read latches high; low write loads
// - only low write clears prescaler
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "count_timer_params.svh"
module count_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic externalCountInput,
   input wire logic lowPowerOscClock,
   input wire logic lowPowerOscEnable,
   input wire logic [1:0] portDirectionBits,
   output logic [1:0] oscPinsInput,
   input wire logic triggerPulse,
   input wire logic [3:0] compareModeSelect,
   output logic [15:0] countValue,
   output logic overflowIrq,
   output logic unit1UsesThis,
   output logic unit2UsesThis
);
   logic [7:0] control_q;
   count_timer_pkg::count_t count_q;
   logic [7:0] highBuffer_q;
   logic flag_q;
   logic irqEnable_q;
   logic [1:0] instrDiv_q;
   logic extSync1_q;
   logic extSync2_q;
   logic ack_q;
   logic [31:0] readdata_q;
   logic [1:0] countKnown_q;
   logic wideMode;
   logic srcExternal;
   logic runBit;
   logic extRaw;
   logic extLevel;
   logic extRise;
   logic instrTick;
   logic countTick;
   logic advance;
   logic access;
   logic wrLow;
   logic wrHigh;
   logic rdLow;
   logic swWrite;
   logic trigClear;
   logic wrap;
   logic flagSet;
   logic flagClear;

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = addr == ofs;
   endfunction : hit

   assign wideMode = control_q[`BIT_WIDE];
   assign srcExternal = control_q[`BIT_SRC_SEL];
   assign runBit = control_q[`BIT_RUN];

   // one-cycle wait then acknowledge each access
   assign access = (read || write) && !ack_q;
   assign waitrequest = (read || write) && !ack_q;
   assign wrLow = write && ack_q && hit(address, `OFS_COUNT_LOW);
   assign wrHigh = write && ack_q && hit(address, `OFS_COUNT_HIGH);
   // latch the high byte at the same edge that captures the low byte
   assign rdLow = read && !ack_q && hit(address, `OFS_COUNT_LOW);
   assign swWrite = wrLow || (wrHigh && !wideMode);
   assign readdata = readdata_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         readdata_q <= `UNMAPPED_READ;
      end else if (read && !ack_q) begin
         unique case (address)
            `OFS_CONTROL: readdata_q <= {24'h000000, control_q};
            `OFS_COUNT_LOW: readdata_q <= {24'h000000, count_q[7:0]};
            `OFS_COUNT_HIGH: readdata_q <= {24'h000000,
               (wideMode ? highBuffer_q : count_q[15:8])};
            `OFS_IRQ: readdata_q <= {30'h00000000, irqEnable_q, flag_q};
            default: readdata_q <= `UNMAPPED_READ;
         endcase
      end
   end

   // only the power-on reset input clears control
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         control_q <= `CTRL_RESET;
      end else if (write && ack_q && hit(address, `OFS_CONTROL)) begin
         control_q <= writedata[7:0];
      end
   end

   // high-byte buffer, written in wide mode, loaded by low read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         highBuffer_q <= 8'h00;
      end else if (wideMode && wrHigh) begin
         highBuffer_q <= writedata[7:0];
      end else if (wideMode && rdLow) begin
         highBuffer_q <= count_q[15:8];
      end
   end

   // instruction cycle: one tick every four core clocks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         instrDiv_q <= 2'h0;
      end else begin
         instrDiv_q <= instrDiv_q + 2'h1;
      end
   end
   assign instrTick = instrDiv_q == `INSTR_DIV;

   // external source: oscillator when enabled, else the count input
   assign extRaw = lowPowerOscEnable ? lowPowerOscClock : externalCountInput;
   assign oscPinsInput = lowPowerOscEnable ? 2'b11 : portDirectionBits;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
      end else begin
         extSync1_q <= extRaw;
         extSync2_q <= extSync1_q;
      end
   end
   // unsynchronised path takes the raw level; ignored for internal source
   assign extLevel = control_q[`BIT_SYNC_DIS] ? extRaw : extSync2_q;

   edge_arm u_edge (
      .clk(clk),
      .reset(reset),
      .enable(srcExternal && runBit),
      .level(extLevel),
      .risePulse(extRise)
   );

   assign countTick = runBit && (srcExternal ? extRise : instrTick);

   prescale_div u_prescale (
      .clk(clk),
      .reset(reset),
      .tick(countTick),
      .clear(wrLow),
      .select(control_q[`BIT_PS_HI:`BIT_PS_LO]),
      .advance(advance)
   );

   // trigger from a compare unit in special-event mode
   assign trigClear = triggerPulse && compareModeSelect == `TRIGGER_MODE;
   assign wrap = advance && count_q == `COUNT_MAX && !swWrite && !trigClear;

   // count bytes are not touched by reset: undefined at power-on, kept otherwise
   always_ff @(posedge clk) begin
      if (wrLow) begin
         count_q <= {(wideMode ? highBuffer_q : count_q[15:8]), writedata[7:0]};
      end else if (wrHigh && !wideMode) begin
         count_q <= {writedata[7:0], count_q[7:0]};
      end else if (trigClear) begin
         count_q <= `COUNT_ZERO;
      end else if (advance) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // assertion helper: which count bytes hold defined values since reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         countKnown_q <= 2'h0;
      end else if ((trigClear && !swWrite) || (wrLow && wideMode)) begin
         countKnown_q <= 2'h3;
      end else begin
         countKnown_q <= countKnown_q | {wrHigh && !wideMode, wrLow};
      end
   end

   assign flagSet = wrap;
   assign flagClear = write && ack_q && hit(address, `OFS_IRQ) && !writedata[`BIT_IRQ_FLAG];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else if (flagSet) begin
         flag_q <= 1'b1;
      end else if (flagClear) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqEnable_q <= 1'b0;
      end else if (write && ack_q && hit(address, `OFS_IRQ)) begin
         irqEnable_q <= writedata[`BIT_IRQ_EN];
      end
   end

   assign overflowIrq = flag_q && irqEnable_q;
   assign countValue = count_q;
   assign unit1UsesThis = control_q[`BIT_TB_UPPER];
   assign unit2UsesThis = control_q[`BIT_TB_UPPER] || control_q[`BIT_TB_LOWER];

   chk_wrap_sets_flag: assert property (@(posedge clk) disable iff (reset)
      wrap |=> flag_q) else $error("overflow flag not set after wrap");
   chk_trigger_no_flag: assert property (@(posedge clk) disable iff (reset)
      (trigClear && !swWrite && !flag_q && !wrap) |=> !flag_q)
      else $error("trigger clear raised flag");
   chk_trigger_zeroes: assert property (@(posedge clk) disable iff (reset)
      (trigClear && !swWrite) |=> count_q == `COUNT_ZERO)
      else $error("trigger did not clear counter");
   chk_write_wins: assert property (@(posedge clk) disable iff (reset)
      (wrLow && trigClear) |=> count_q[7:0] == $past(writedata[7:0]))
      else $error("write lost to trigger");
   chk_stop_holds: assert property (@(posedge clk) disable iff (reset)
      (!runBit && !swWrite && !trigClear && countKnown_q == 2'h3) |=> count_q == $past(count_q))
      else $error("counter moved while stopped");
   chk_irq_gate: assert property (@(posedge clk) disable iff (reset)
      overflowIrq |-> irqEnable_q) else $error("irq without enable");
   chk_low_read_latch: assert property (@(posedge clk) disable iff (reset)
      (rdLow && wideMode) |=> highBuffer_q == $past(count_q[15:8]))
      else $error("high buffer not latched");
   sequence wrapStep;
      advance && count_q == `COUNT_MAX && !swWrite && !trigClear;
   endsequence
   chk_wrap_zero: assert property (@(posedge clk) disable iff (reset)
      wrapStep |=> count_q == `COUNT_ZERO) else $error("no wrap to zero");
   chk_osc_pins: assert property (@(posedge clk) disable iff (reset)
      lowPowerOscEnable |-> oscPinsInput == 2'b11) else $error("osc pins not input");

   sequence trigStep;
      trigClear && !swWrite;
   endsequence
   sequence wideLoad;
      wrLow && wideMode;
   endsequence
   sequence plainStep;
      advance && !swWrite && !trigClear && countKnown_q == 2'h3;
   endsequence

   chk_count_step: assert property (@(posedge clk) disable iff (reset)
      plainStep |=> count_q == $past(count_q) + 16'h0001)
      else $error("counter did not step by one");
   chk_trigger_flag: assert property (@(posedge clk) disable iff (reset)
      trigStep |=> flag_q == ($past(flag_q) && !$past(flagClear)))
      else $error("trigger changed overflow flag");
   chk_trigger_mode: assert property (@(posedge clk) disable iff (reset)
      (compareModeSelect != `TRIGGER_MODE) |-> !trigClear)
      else $error("trigger acted in wrong mode");
   chk_wide_load: assert property (@(posedge clk) disable iff (reset)
      wideLoad |=> count_q == {$past(highBuffer_q), $past(writedata[7:0])})
      else $error("wide low write did not load buffer");
   chk_buffer_write: assert property (@(posedge clk) disable iff (reset)
      (wrHigh && wideMode) |=> highBuffer_q == $past(writedata[7:0]))
      else $error("high buffer not written");
   chk_wide_high_held: assert property (@(posedge clk) disable iff (reset)
      (wrHigh && wideMode && !trigClear && !advance && countKnown_q == 2'h3)
         |=> count_q == $past(count_q))
      else $error("wide high write reached counter");
   chk_byte_high: assert property (@(posedge clk) disable iff (reset)
      (wrHigh && !wideMode) |=> count_q[15:8] == $past(writedata[7:0]))
      else $error("byte high write lost");
   chk_byte_low: assert property (@(posedge clk) disable iff (reset)
      wrLow |=> count_q[7:0] == $past(writedata[7:0]))
      else $error("low write lost");
   chk_buffer_read: assert property (@(posedge clk) disable iff (reset)
      (read && !ack_q && hit(address, `OFS_COUNT_HIGH) && wideMode)
         |=> readdata[7:0] == $past(highBuffer_q))
      else $error("wide high read not from buffer");
   chk_ctrl_write: assert property (@(posedge clk) disable iff (reset)
      (write && ack_q && hit(address, `OFS_CONTROL))
         |=> control_q == $past(writedata[7:0]))
      else $error("control write lost");
   chk_stop_no_tick: assert property (@(posedge clk) disable iff (reset)
      !runBit |-> !advance)
      else $error("advance while stopped");
   chk_internal_rate: assert property (@(posedge clk) disable iff (reset)
      (advance && !srcExternal) |-> instrTick)
      else $error("internal advance off instruction tick");
   chk_external_edge: assert property (@(posedge clk) disable iff (reset)
      (advance && srcExternal) |-> extRise)
      else $error("external advance without rising edge");
   chk_no_early_rise: assert property (@(posedge clk) disable iff (reset)
      $rose(srcExternal && runBit) |-> !extRise)
      else $error("edge counted before a fall");
   chk_raw_path: assert property (@(posedge clk) disable iff (reset)
      (srcExternal && control_q[`BIT_SYNC_DIS]) |-> extLevel == extRaw)
      else $error("unsynchronised path not raw");
   chk_sync_path: assert property (@(posedge clk) disable iff (reset)
      !control_q[`BIT_SYNC_DIS] |-> extLevel == extSync2_q)
      else $error("synchronised path not used");
   chk_osc_source: assert property (@(posedge clk) disable iff (reset)
      lowPowerOscEnable |-> extRaw == lowPowerOscClock)
      else $error("oscillator not used as source");
   chk_pins_follow: assert property (@(posedge clk) disable iff (reset)
      !lowPowerOscEnable |-> oscPinsInput == portDirectionBits)
      else $error("pin direction not followed");
   chk_base_both: assert property (@(posedge clk) disable iff (reset)
      control_q[`BIT_TB_UPPER] |-> (unit1UsesThis && unit2UsesThis))
      else $error("time base not given to both units");
   chk_base_split: assert property (@(posedge clk) disable iff (reset)
      (!control_q[`BIT_TB_UPPER] && control_q[`BIT_TB_LOWER])
         |-> (!unit1UsesThis && unit2UsesThis))
      else $error("split time base wrong");
   chk_base_other: assert property (@(posedge clk) disable iff (reset)
      (!control_q[`BIT_TB_UPPER] && !control_q[`BIT_TB_LOWER])
         |-> (!unit1UsesThis && !unit2UsesThis))
      else $error("time base not released");
   chk_flag_holds: assert property (@(posedge clk) disable iff (reset)
      (flag_q && !flagClear) |=> flag_q)
      else $error("overflow flag dropped");
   chk_irq_follow: assert property (@(posedge clk) disable iff (reset)
      (flag_q && irqEnable_q) |-> overflowIrq)
      else $error("enabled flag gave no irq");
   chk_prescale_one: assert property (@(posedge clk) disable iff (reset)
      (countTick && control_q[`BIT_PS_HI:`BIT_PS_LO] == 2'h0) |-> advance)
      else $error("divide by one skipped a tick");
endmodule : count_timer

// File: hw/count_timer_params.svh
// register offsets, field positions and constants for the 16-bit counter
`ifndef COUNT_TIMER_PARAMS_SVH
`define COUNT_TIMER_PARAMS_SVH
`define OFS_CONTROL 4'h0
`define OFS_COUNT_LOW 4'h4
`define OFS_COUNT_HIGH 4'h8
`define OFS_IRQ 4'hC
`define BIT_WIDE 7
`define BIT_TB_UPPER 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_TB_LOWER 3
`define BIT_SYNC_DIS 2
`define BIT_SRC_SEL 1
`define BIT_RUN 0
`define BIT_IRQ_FLAG 0
`define BIT_IRQ_EN 1
`define CTRL_RESET 8'h00
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define TRIGGER_MODE 4'hB
`define INSTR_DIV 2'h3
`define UNMAPPED_READ 32'h00000000
`endif

// File: hw/count_timer_pkg.sv
// types shared by the 16-bit counter design
package count_timer_pkg;
   typedef enum logic [1:0] {
      EDGE_WAIT_FALL = 2'b00,
      EDGE_ARMED = 2'b01
   } edge_state_t;
   typedef logic [15:0] count_t;
endpackage : count_timer_pkg

// File: hw/edge_arm.sv
// rising-edge detector that only arms after a falling edge has been seen
`timescale 1ns/1ps
`include "count_timer_params.svh"
module edge_arm (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic level,
   output logic risePulse
);
   count_timer_pkg::edge_state_t state_q;
   logic prev_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= count_timer_pkg::EDGE_WAIT_FALL;
      end else if (!enable) begin
         state_q <= count_timer_pkg::EDGE_WAIT_FALL;
      end else begin
         unique case (state_q)
            count_timer_pkg::EDGE_WAIT_FALL: begin
               if (prev_q && !level) begin
                  state_q <= count_timer_pkg::EDGE_ARMED;
               end
            end
            count_timer_pkg::EDGE_ARMED: begin
            end
            default: state_q <= count_timer_pkg::EDGE_WAIT_FALL;
         endcase
      end
   end
   // counting starts at the first rise after a fall
   assign risePulse = enable && state_q == count_timer_pkg::EDGE_ARMED && !prev_q && level;
endmodule : edge_arm

// File: hw/prescale_div.sv
// 1/2/4/8 prescaler producing one advance per divided tick
`timescale 1ns/1ps
`include "count_timer_params.svh"
module prescale_div (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic clear,
   input wire logic [1:0] select,
   output logic advance
);
   logic [2:0] count_q;
   logic [2:0] limit;
   always_comb begin
      unique case (select)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end
   assign advance = tick && count_q >= limit;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= 3'h0;
      end else if (clear) begin
         count_q <= 3'h0;
      end else if (tick) begin
         count_q <= (count_q >= limit) ? 3'h0 : count_q + 3'h1;
      end
   end
endmodule : prescale_div

// File: verification/count_timer_bench.sv
// self-checking bench for the 16-bit counter and its register slave
`timescale 1ns/1ps
`include "count_timer_params.svh"
module count_timer_bench;
   logic clk, reset, read, write, extIn, oscClk, oscEn, trig, ovfIrq, unit1, unit2;
   logic waitrequest;
   logic [3:0] address, modeSel;
   logic [31:0] writedata, readdata, rd, lfsr;
   logic [1:0] dirBits, pinsIn;
   count_timer_pkg::count_t countValue, val, v;
   int fail_count, checked, i, k;
   count_timer u_count_timer (
      .clk(clk),
      .reset(reset),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .externalCountInput(extIn),
      .lowPowerOscClock(oscClk),
      .lowPowerOscEnable(oscEn),
      .portDirectionBits(dirBits),
      .oscPinsInput(pinsIn),
      .triggerPulse(trig),
      .compareModeSelect(modeSel),
      .countValue(countValue),
      .overflowIrq(ovfIrq),
      .unit1UsesThis(unit1),
      .unit2UsesThis(unit2)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext
   function automatic logic [15:0] expTrig(input logic [3:0] m, input logic [15:0] c);
      return (m == `TRIGGER_MODE) ? `COUNT_ZERO : c;
   endfunction : expTrig
   function automatic logic [15:0] expPeriod(input int p);
      return 16'(`INSTR_DIV + 1) << p;
   endfunction : expPeriod
   task automatic report_and_stop();
      $display("counts: %0d checked, %0d failed", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic giveUp(input string s);
      fail_count++;
      $display("[FAIL] %0t timeout: %s", $time, s);
      report_and_stop();
   endtask : giveUp
   task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, s, got, exp);
      end
   endtask : cmpVal
   task automatic cmpBit(input logic got, input logic exp, input string s);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: got %b want %b", $time, s, got, exp);
      end
   endtask : cmpBit
   // one Avalon transfer; read data kept in rd, one idle cycle after
   task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= {24'h000000, d};
      read <= ~wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) giveUp("waitrequest");
      // the edge that sees waitrequest low ends the request and carries read data
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic setCount(input logic [15:0] c);
      bus(`OFS_COUNT_HIGH, 1'b1, c[15:8]);
      bus(`OFS_COUNT_LOW, 1'b1, c[7:0]);
   endtask : setCount
   task automatic waitChange(output int n);
      @(negedge clk);
      val = countValue;
      n = 1;
      do begin
         @(negedge clk);
         n++;
      end while (countValue === val && n < 200);
      if (n >= 200) giveUp("count stalled");
   endtask : waitChange
   task automatic level(input logic osc, input logic b);
      if (osc) oscClk <= b;
      else extIn <= b;
      repeat (4) @(posedge clk);
   endtask : level
   initial begin
      reset = 1'b1;
      {read, write, extIn, oscClk, oscEn, trig} = 6'h00;
      {address, modeSel, dirBits} = 10'h000;
      writedata = 32'h00000000;
      lfsr = 32'h5C4A;
      fail_count = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      bus(`OFS_CONTROL, 1'b0, 8'h00);
      cmpVal(rd[7:0], `CTRL_RESET, "control at reset");
      bus(`OFS_IRQ, 1'b0, 8'h00);
      cmpBit(rd[`BIT_IRQ_FLAG], 1'b0, "flag at reset");
      bus(4'h1, 1'b0, 8'h00);
      cmpVal(rd[15:0], 16'h0000, "unmapped read");
      lfsr = lfsrNext(lfsr);
      v = lfsr[15:0];
      setCount(v);
      cmpVal(countValue, v, "byte write");
      bus(`OFS_COUNT_HIGH, 1'b0, 8'h00);
      cmpVal(rd[7:0], v[15:8], "byte read high");
      $display("test reset and byte access done");
      // wide mode: high goes through the buffer
      bus(`OFS_CONTROL, 1'b1, 8'h80);
      bus(`OFS_COUNT_HIGH, 1'b1, 8'h12);
      cmpVal(countValue, v, "wide high write held");
      bus(`OFS_COUNT_LOW, 1'b1, 8'h34);
      cmpVal(countValue, 16'h1234, "wide low write");
      bus(`OFS_COUNT_LOW, 1'b0, 8'h00);
      bus(`OFS_CONTROL, 1'b1, 8'h00);
      bus(`OFS_COUNT_HIGH, 1'b1, 8'h77);
      bus(`OFS_CONTROL, 1'b1, 8'h80);
      bus(`OFS_COUNT_HIGH, 1'b0, 8'h00);
      cmpVal(rd[7:0], 8'h12, "wide high reads buffer");
      bus(`OFS_CONTROL, 1'b1, 8'h00);
      bus(`OFS_COUNT_HIGH, 1'b0, 8'h00);
      cmpVal(rd[7:0], 8'h77, "byte high direct");
      $display("test wide access done");
      for (i = 0; i < 4; i++) begin
         bus(`OFS_CONTROL, 1'b1, {1'b0, i[1], 2'b00, i[0], 3'b000});
         cmpBit(unit1, i[1], "unit1 base");
         cmpBit(unit2, i[1] | i[0], "unit2 base");
      end
      for (i = 0; i < 4; i++) begin
         bus(`OFS_CONTROL, 1'b1, {2'b00, i[1:0], 4'b0001});
         waitChange(k);
         waitChange(k);
         cmpVal(16'(k), expPeriod(i), "tick period");
      end
      bus(`OFS_CONTROL, 1'b1, 8'h00);
      @(negedge clk);
      v = countValue;
      repeat (40) @(negedge clk);
      cmpVal(countValue, v, "stopped holds");
      $display("test prescale and stop done");
      bus(`OFS_IRQ, 1'b1, 8'h02);
      setCount(16'hFFFD);
      bus(`OFS_CONTROL, 1'b1, 8'h01);
      for (i = 0; i < 4 && countValue !== `COUNT_MAX; i++) waitChange(k);
      cmpVal(countValue, `COUNT_MAX, "reach top");
      waitChange(k);
      cmpVal(countValue, `COUNT_ZERO, "wrap to zero");
      bus(`OFS_CONTROL, 1'b1, 8'h00);
      bus(`OFS_IRQ, 1'b0, 8'h00);
      cmpBit(rd[`BIT_IRQ_FLAG], 1'b1, "flag on wrap");
      cmpBit(ovfIrq, 1'b1, "irq enabled");
      bus(`OFS_IRQ, 1'b1, 8'h01);
      cmpBit(ovfIrq, 1'b0, "irq masked");
      bus(`OFS_IRQ, 1'b1, 8'h00);
      $display("test overflow done");
      // trigger used in stopped timer mode only
      for (i = 0; i < 16; i++) begin
         lfsr = lfsrNext(lfsr);
         v = lfsr[15:0] | 16'h0100;
         setCount(v);
         modeSel <= i[3:0];
         trig <= 1'b1;
         @(posedge clk);
         trig <= 1'b0;
         @(negedge clk);
         cmpVal(countValue, expTrig(i[3:0], v), "trigger");
      end
      bus(`OFS_IRQ, 1'b0, 8'h00);
      cmpBit(rd[`BIT_IRQ_FLAG], 1'b0, "no flag on trigger");
      setCount(16'h3300);
      modeSel <= `TRIGGER_MODE;
      fork
         bus(`OFS_COUNT_LOW, 1'b1, 8'h5A);
         begin
            repeat (2) @(posedge clk);
            trig <= 1'b1;
            @(posedge clk);
            trig <= 1'b0;
         end
      join
      cmpVal(countValue, 16'h335A, "write beats trigger");
      $display("test trigger done");
      for (i = 0; i < 3; i++) begin
         lfsr = lfsrNext(lfsr);
         k = lfsr[2:0] + 1;
         dirBits <= lfsr[4:3];
         oscEn <= (i == 2);
         v = countValue;
         bus(`OFS_CONTROL, 1'b1, {5'b00000, i[0], 2'b11});
         cmpVal(16'(pinsIn), (i == 2) ? 16'h0003 : 16'(lfsr[4:3]), "osc pins");
         level(i == 2, 1'b1);
         level(i == 2, 1'b0);
         repeat (k) begin
            level(i == 2, 1'b1);
            level(i == 2, 1'b0);
         end
         bus(`OFS_CONTROL, 1'b1, 8'h00);
         cmpVal(countValue, v + 16'(k), "edge count");
      end
      $display("test external clock done");
      bus(`OFS_CONTROL, 1'b1, 8'hA4);
      v = countValue;
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      cmpVal(countValue, v, "count kept on reset");
      bus(`OFS_CONTROL, 1'b0, 8'h00);
      cmpVal(rd[7:0], `CTRL_RESET, "control cleared");
      $display("test second reset done");
      report_and_stop();
   end
endmodule : count_timer_bench
